// File: clk_div_switch.sv
`timescale 1ns/1ns
`default_nettype none
module clk_div_switch (
	// Clock and control
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       run,
	// Requested setting
	input  wire logic [1:0] req_src,
	input  wire logic [2:0] req_div,
	input  wire logic       req_pre,
	// Active setting and output
	output logic      [1:0] act_src,
	output logic      [2:0] act_div,
	output logic            act_pre,
	output logic            tick,
	output logic            busy
);

	logic [6:0] cnt_r;
	logic [1:0] phase_r;
	logic       src_pulse;
	logic       boundary;

	function automatic logic is_internal(input logic [1:0] src);
		is_internal = (src == pmc_pkg::SRC_OSC_24M5) || (src == pmc_pkg::SRC_OSC_72M);
	endfunction : is_internal

	// 1.5x prescale passes two source edges out of three
	assign src_pulse = ~act_pre | (phase_r != pmc_pkg::PRESCALE_LAST_PHASE);
	assign boundary = run & src_pulse & (cnt_r == 7'((8'h01 << act_div) - 8'h01));

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= 7'h00;
			phase_r <= 2'h0;
			tick <= 1'b0;
		end else if (ce) begin
			tick <= boundary;
			if (run) begin
				// Phase runs free across wraps, or the 1.5x stretch would be lost at short divides
				if (!act_pre || phase_r == pmc_pkg::PRESCALE_LAST_PHASE) begin
					phase_r <= 2'h0;
				end else begin
					phase_r <= phase_r + 2'h1;
				end
				if (boundary) begin
					cnt_r <= 7'h00;
				end else if (src_pulse) begin
					cnt_r <= cnt_r + 7'h01;
				end
			end
		end
	end

	// Settings only move at a divider wrap, so no output period is ever cut short
	always_ff @(posedge clk) begin
		if (srst) begin
			act_src <= pmc_pkg::SRC_RESET;
			act_div <= pmc_pkg::DIV_RESET;
			act_pre <= 1'b0;
			busy <= 1'b0;
		end else if (ce) begin
			if (boundary) begin
				act_src <= req_src;
				act_div <= req_div;
				act_pre <= req_pre & is_internal(req_src);
			end
			busy <= (req_src != act_src) || (req_div != act_div)
				|| ((req_pre & is_internal(req_src)) != act_pre);
		end
	end

	reset_clock_a: assert property (@(posedge clk)
		srst |=> act_src == pmc_pkg::SRC_OSC_24M5 && act_div == 3'h3 && !act_pre)
		else $error("reset clock is not 24.5 MHz divided by eight");

	switch_boundary_a: assert property (@(posedge clk) disable iff (srst)
		!boundary |=> $stable(act_src) && $stable(act_div) && $stable(act_pre))
		else $error("clock setting changed off a divider boundary");

	prescale_src_a: assert property (@(posedge clk) disable iff (srst)
		act_pre |-> is_internal(act_src))
		else $error("prescale active on a non-internal source");

	divide_one_a: assert property (@(posedge clk) disable iff (srst)
		ce && run && act_div == 3'h0 && !act_pre |=> tick)
		else $error("divide by one missed a tick");

endmodule : clk_div_switch
`default_nettype wire

// File: pmc_pkg.sv
// Operation
// - Normal mode keeps core and all peripherals clocked and running.
// - Idle bit halts core only; any interrupt wakes and execution continues.
// - Suspend stops core, peripheral clocks and both fast oscillators; regulator bias normal.
// - In suspend and snooze timers three and four may run from low-frequency clock.
// - Timer four, serial, two-wire, port match, comparator fall or logic-unit events wake.
// - After wake from suspend or snooze, clocks restart and code continues without reset.
// - Snooze stops core, peripheral clocks and fast oscillators; regulator in low bias.
// - Stop powers down internal nets, pins hold state, any reset ends it.
// - Shutdown powers nets off, pins hold; only pin reset or power-on reset exit.
// - Clocks of unused digital peripherals are gated off.
// - After reset the system clock is the 24.5 MHz oscillator divided by eight.
// - Clock sources are 24.5 MHz, 72 MHz, 80 kHz and an external clock.
// - Divider divides the selected source by a power of two from 1 to 128.
// - Both internal fast oscillators offer an optional 1.5x prescale before the divider.
package pmc_pkg;

	// ============================================================
	// Register byte offsets
	localparam logic [7:0] OFS_POWER_CONTROL_A = 8'h00;
	localparam logic [7:0] OFS_POWER_CONTROL_B = 8'h04;
	localparam logic [7:0] OFS_REGULATOR_CONTROL = 8'h08;
	localparam logic [7:0] OFS_CLOCK_SELECT = 8'h0c;
	localparam logic [7:0] OFS_PERIPH_GATE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ============================================================
	// Field positions
	localparam int PA_IDLE = 0;
	localparam int PA_STOP = 1;
	localparam int PB_SUSPEND = 0;
	localparam int PB_SNOOZE = 1;
	localparam int PB_LF_TIMER = 2;
	localparam int RC_STOP_SELECT = 0;
	localparam int CS_SRC_LSB = 0;
	localparam int CS_DIV_LSB = 4;
	localparam int CS_PRESCALE = 8;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_BUSY = 8;
	localparam int ST_SRC_LSB = 16;
	localparam int ST_DIV_LSB = 20;
	localparam int ST_PRESCALE = 24;

	// ============================================================
	// Clock sources and reset values
	localparam logic [1:0] SRC_OSC_24M5 = 2'h0;
	localparam logic [1:0] SRC_OSC_72M = 2'h1;
	localparam logic [1:0] SRC_LOW_FREQ = 2'h2;
	localparam logic [1:0] SRC_EXTERNAL = 2'h3;
	localparam logic [1:0] SRC_RESET = SRC_OSC_24M5;
	localparam logic [2:0] DIV_RESET = 3'h3;
	localparam logic [7:0] PERIPH_GATE_RESET = 8'hff;
	localparam logic [1:0] PRESCALE_LAST_PHASE = 2'h2;

	// ============================================================
	// Power modes
	typedef enum logic [5:0] {
		ST_NORMAL   = 6'h01,
		ST_IDLE     = 6'h02,
		ST_SUSPEND  = 6'h04,
		ST_SNOOZE   = 6'h08,
		ST_STOP     = 6'h10,
		ST_SHUTDOWN = 6'h20
	} pmode_e;

endpackage : pmc_pkg

// File: power_mode_and_clock_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module power_mode_and_clock_control_test;
	logic        clk;
	logic        srst;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [9:0]  ev;
	logic        core_en;
	logic [7:0]  periph_en;
	logic        o24;
	logic        o72;
	logic        lf_en;
	logic        low_bias;
	logic        nets_off;
	logic        retain;
	logic        tick;
	logic [1:0]  src;
	logic [2:0]  div;
	logic        pre;
	int          miscompares;
	int          n_checks;
	logic [31:0] rv;
	logic        er;

	power_mode_ctrl dut_u (
		.CLK(clk), .SRST(srst), .CE(ce),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.IRQ_ANY(ev[6]), .TIMER4_EVENT(ev[0]), .SPI_ACTIVITY(ev[1]),
		.I2C_SLAVE_ACTIVITY(ev[2]), .PORT_MATCH(ev[3]), .CMP0_OUT(~ev[4]),
		.CLU_IRQ_EVENT(ev[5]), .EXTERNAL_RESET_PIN_N(~ev[8]), .POR_EVENT(ev[9]),
		.OTHER_RESET_EVENT(ev[7]), .CORE_CLK_EN(core_en), .PERIPH_CLK_EN(periph_en),
		.OSC_24M5_EN(o24), .OSC_72M_EN(o72), .TIMER34_LF_CLK_EN(lf_en),
		.REG_LOW_BIAS(low_bias), .POWER_NETS_OFF(nets_off), .PIN_RETAIN(retain),
		.SYS_CLK_TICK(tick), .CLK_SRC_SEL(src), .CLK_DIV_SEL(div), .CLK_PRESCALE_ON(pre)
	);

	// ============================================================
	// Helpers
	function automatic logic [31:0] pk(input logic c, input logic [7:0] p, input logic a,
		input logic lf, input logic lb, input logic off);
		return {17'h0, c, p, a, 1'b0, lf, lb, off, off};
	endfunction : pk

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_out(input logic [31:0] exp);
		chk({17'h0, core_en, periph_en, o24, o72, lf_en, low_bias, nets_off, retain}, exp);
	endtask : chk_out

	task automatic chk_ticks(input int span, input int exp);
		int t;
		t = 0;
		repeat (span) begin
			@(posedge clk);
			if (tick === 1'b1)
				t++;
		end
		chk(t, exp);
	endtask : chk_ticks

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Request held until pready is sampled high
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
		chk({31'h0, er}, 32'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h0);
		chk(rv, exp);
	endtask : rd

	// Events are held two cycles; the comparator fall is seen on the first sample only
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		repeat (2) @(posedge clk);
		ev[i] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// ============================================================
	// Clock, reset and watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#80000;
		miscompares++;
		stop_test;
	end

	// ============================================================
	// Tests
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 10'h000;
		miscompares = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		chk_out(pk(1'b1, 8'hff, 1'b1, 1'b0, 1'b0, 1'b0));
		rd(pmc_pkg::OFS_STATUS, 32'h00300001);
		chk({27'h0, src, div}, {27'h0, pmc_pkg::SRC_OSC_24M5, 3'h3});
		apb(8'h18, 1'b0, 32'h0);
		chk({er, rv[30:0]}, 32'h80000000);
		$display("test reset_and_map done");

		wr(pmc_pkg::OFS_PERIPH_GATE, 32'h0000000f);
		repeat (3) @(posedge clk);
		chk_out(pk(1'b1, 8'h0f, 1'b1, 1'b0, 1'b0, 1'b0));
		wr(pmc_pkg::OFS_POWER_CONTROL_A, 32'h1);
		repeat (4) @(posedge clk);
		chk_out(pk(1'b0, 8'h0f, 1'b1, 1'b0, 1'b0, 1'b0));
		pulse(6);
		chk_out(pk(1'b1, 8'h0f, 1'b1, 1'b0, 1'b0, 1'b0));
		rd(pmc_pkg::OFS_POWER_CONTROL_A, 32'h0);
		$display("test gate_and_idle done");

		// Even passes use suspend, odd passes snooze; each wake source used once
		for (int i = 0; i < 6; i++) begin
			wr(pmc_pkg::OFS_POWER_CONTROL_B, i[0] ? 32'h6 : 32'h5);
			repeat (4) @(posedge clk);
			chk_out(pk(1'b0, 8'h00, 1'b0, 1'b1, i[0], 1'b0));
			pulse(i);
			chk_out(pk(1'b1, 8'h0f, 1'b1, 1'b0, 1'b0, 1'b0));
			rd(pmc_pkg::OFS_POWER_CONTROL_B, 32'h4);
		end
		$display("test suspend_snooze done");

		wr(pmc_pkg::OFS_REGULATOR_CONTROL, 32'h0);
		wr(pmc_pkg::OFS_POWER_CONTROL_A, 32'h2);
		repeat (4) @(posedge clk);
		chk_out(pk(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1));
		pulse(7);
		chk_out(pk(1'b1, 8'hff, 1'b1, 1'b0, 1'b0, 1'b0));
		wr(pmc_pkg::OFS_REGULATOR_CONTROL, 32'h1);
		wr(pmc_pkg::OFS_POWER_CONTROL_A, 32'h2);
		repeat (4) @(posedge clk);
		chk_out(pk(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1));
		pulse(7);
		chk_out(pk(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1));
		pulse(8);
		chk_out(pk(1'b1, 8'hff, 1'b1, 1'b0, 1'b0, 1'b0));
		rd(pmc_pkg::OFS_REGULATOR_CONTROL, 32'h0);
		wr(pmc_pkg::OFS_REGULATOR_CONTROL, 32'h1);
		wr(pmc_pkg::OFS_POWER_CONTROL_A, 32'h2);
		pulse(9);
		chk_out(pk(1'b1, 8'hff, 1'b1, 1'b0, 1'b0, 1'b0));
		$display("test stop_shutdown done");

		// Every source and both ends of the divider; prescale only counts on fast sources
		for (int k = 0; k < 5; k++) begin
			logic [2:0]  dv;
			logic        pe;
			logic [31:0] st;
			dv = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : (k == 4) ? 3'h3 : 3'(k + 2);
			pe = (k % 4 != 0);
			wr(pmc_pkg::OFS_CLOCK_SELECT, {23'h0, pe, 1'b0, dv, 2'h0, 2'(k)});
			st = 32'h100;
			for (int n = 0; n < 100 && st[8] !== 1'b0; n++) begin
				apb(pmc_pkg::OFS_STATUS, 1'b0, 32'h0);
				st = rv;
			end
			chk(st, {7'h0, pe & (k % 4 < 2), 1'b0, dv, 2'h0, 2'(k), 16'h0001});
			chk({26'h0, src, dv, pre}, {26'h0, 2'(k), div, pe & (k % 4 < 2)});
			chk({31'h0, o72}, {31'h0, k == 1});
		end
		chk_ticks(512, 64);
		// 1.5x ahead of a divide by four gives one tick every six cycles
		wr(pmc_pkg::OFS_CLOCK_SELECT, 32'h0000_0120);
		rv = 32'h100;
		for (int n = 0; n < 100 && rv[8] !== 1'b0; n++)
			apb(pmc_pkg::OFS_STATUS, 1'b0, 32'h0);
		chk(rv, 32'h0120_0001);
		chk_ticks(384, 64);
		$display("test clock_select done");

		// Clock enable low freezes the divider, which resumes in phase
		for (int n = 0; n < 20 && tick !== 1'b1; n++)
			@(posedge clk);
		ce <= 1'b0;
		chk_ticks(64, 0);
		ce <= 1'b1;
		chk_ticks(384, 64);
		$display("test clock_enable done");

		// Reset in mid-run restores the default mode and clock
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		chk_out(pk(1'b1, 8'hff, 1'b1, 1'b0, 1'b0, 1'b0));
		rd(pmc_pkg::OFS_STATUS, 32'h00300001);
		$display("test mid_reset done");
		stop_test;
	end
endmodule : power_mode_and_clock_control_test
`default_nettype wire

// File: power_mode_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module power_mode_ctrl (
	// Clock and control
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        CE,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Wake sources
	input  wire logic        IRQ_ANY,
	input  wire logic        TIMER4_EVENT,
	input  wire logic        SPI_ACTIVITY,
	input  wire logic        I2C_SLAVE_ACTIVITY,
	input  wire logic        PORT_MATCH,
	input  wire logic        CMP0_OUT,
	input  wire logic        CLU_IRQ_EVENT,
	// Reset sources
	input  wire logic        EXTERNAL_RESET_PIN_N,
	input  wire logic        POR_EVENT,
	input  wire logic        OTHER_RESET_EVENT,
	// Power and clock controls
	output logic             CORE_CLK_EN,
	output logic      [7:0]  PERIPH_CLK_EN,
	output logic             OSC_24M5_EN,
	output logic             OSC_72M_EN,
	output logic             TIMER34_LF_CLK_EN,
	output logic             REG_LOW_BIAS,
	output logic             POWER_NETS_OFF,
	output logic             PIN_RETAIN,
	// System clock
	output logic             SYS_CLK_TICK,
	output logic      [1:0]  CLK_SRC_SEL,
	output logic      [2:0]  CLK_DIV_SEL,
	output logic             CLK_PRESCALE_ON
);

	// ============================================================
	// Declarations
	pmc_pkg::pmode_e state_r;
	pmc_pkg::pmode_e state_nxt;
	logic        pready_r;
	logic        wr_en;
	logic        rd_en;
	logic        idle_req_r;
	logic        stop_req_r;
	logic        suspend_req_r;
	logic        snooze_req_r;
	logic        lf_timer_en_r;
	logic        stop_sel_r;
	logic [1:0]  src_sel_r;
	logic [2:0]  div_sel_r;
	logic        pre_sel_r;
	logic [7:0]  periph_gate_r;
	logic        wake;
	logic        clk_busy;
	logic        soft_rst;
	logic        any_reset;
	logic        hard_reset;
	logic        wake_return;
	logic        running;
	logic        low_power;

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == pmc_pkg::OFS_POWER_CONTROL_A) || (a == pmc_pkg::OFS_POWER_CONTROL_B)
			|| (a == pmc_pkg::OFS_REGULATOR_CONTROL) || (a == pmc_pkg::OFS_CLOCK_SELECT)
			|| (a == pmc_pkg::OFS_PERIPH_GATE) || (a == pmc_pkg::OFS_STATUS);
	endfunction : addr_hit

	// ============================================================
	// APB slave: one wait state, answer in second access cycle
	assign wr_en = PSEL & PENABLE & pready_r & PWRITE & CE;
	assign rd_en = PSEL & PENABLE & ~pready_r;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			pready_r <= 1'b0;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			pready_r <= rd_en;
			PSLVERR <= rd_en & ~addr_hit(PADDR);
		end
	end

	assign PREADY = pready_r;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			PRDATA <= 32'h0000_0000;
		end else if (CE && rd_en) begin
			PRDATA <= 32'h0000_0000;
			unique case (PADDR)
				pmc_pkg::OFS_POWER_CONTROL_A: begin
					PRDATA[pmc_pkg::PA_IDLE] <= idle_req_r;
					PRDATA[pmc_pkg::PA_STOP] <= stop_req_r;
				end
				pmc_pkg::OFS_POWER_CONTROL_B: begin
					PRDATA[pmc_pkg::PB_SUSPEND] <= suspend_req_r;
					PRDATA[pmc_pkg::PB_SNOOZE] <= snooze_req_r;
					PRDATA[pmc_pkg::PB_LF_TIMER] <= lf_timer_en_r;
				end
				pmc_pkg::OFS_REGULATOR_CONTROL: begin
					PRDATA[pmc_pkg::RC_STOP_SELECT] <= stop_sel_r;
				end
				pmc_pkg::OFS_CLOCK_SELECT: begin
					PRDATA[pmc_pkg::CS_SRC_LSB +: 2] <= src_sel_r;
					PRDATA[pmc_pkg::CS_DIV_LSB +: 3] <= div_sel_r;
					PRDATA[pmc_pkg::CS_PRESCALE] <= pre_sel_r;
				end
				pmc_pkg::OFS_PERIPH_GATE: begin
					PRDATA[7:0] <= periph_gate_r;
				end
				pmc_pkg::OFS_STATUS: begin
					PRDATA[pmc_pkg::ST_MODE_LSB +: 6] <= state_r;
					PRDATA[pmc_pkg::ST_BUSY] <= clk_busy;
					PRDATA[pmc_pkg::ST_SRC_LSB +: 2] <= CLK_SRC_SEL;
					PRDATA[pmc_pkg::ST_DIV_LSB +: 3] <= CLK_DIV_SEL;
					PRDATA[pmc_pkg::ST_PRESCALE] <= CLK_PRESCALE_ON;
				end
				default: begin
				end
			endcase
		end
	end

	// ============================================================
	// Reset exits from the powered-down modes
	assign any_reset = ~EXTERNAL_RESET_PIN_N | POR_EVENT | OTHER_RESET_EVENT;
	assign hard_reset = ~EXTERNAL_RESET_PIN_N | POR_EVENT;
	assign soft_rst = CE & (((state_r == pmc_pkg::ST_STOP) & any_reset)
		| ((state_r == pmc_pkg::ST_SHUTDOWN) & hard_reset));
	assign wake_return = ((state_r == pmc_pkg::ST_IDLE) & IRQ_ANY)
		| (((state_r == pmc_pkg::ST_SUSPEND) | (state_r == pmc_pkg::ST_SNOOZE)) & wake);

	// ============================================================
	// Power request bits; a write in the wake cycle wins over the clear
	always_ff @(posedge CLK) begin
		if (SRST || soft_rst) begin
			idle_req_r <= 1'b0;
			stop_req_r <= 1'b0;
			suspend_req_r <= 1'b0;
			snooze_req_r <= 1'b0;
			lf_timer_en_r <= 1'b0;
		end else if (CE) begin
			if (wake_return) begin
				idle_req_r <= 1'b0;
				suspend_req_r <= 1'b0;
				snooze_req_r <= 1'b0;
			end
			if (wr_en && PADDR == pmc_pkg::OFS_POWER_CONTROL_A) begin
				idle_req_r <= PWDATA[pmc_pkg::PA_IDLE];
				stop_req_r <= PWDATA[pmc_pkg::PA_STOP];
			end
			if (wr_en && PADDR == pmc_pkg::OFS_POWER_CONTROL_B) begin
				suspend_req_r <= PWDATA[pmc_pkg::PB_SUSPEND];
				snooze_req_r <= PWDATA[pmc_pkg::PB_SNOOZE];
				lf_timer_en_r <= PWDATA[pmc_pkg::PB_LF_TIMER];
			end
		end
	end

	// ============================================================
	// Regulator and clock configuration
	always_ff @(posedge CLK) begin
		if (SRST || soft_rst) begin
			stop_sel_r <= 1'b0;
			src_sel_r <= pmc_pkg::SRC_RESET;
			div_sel_r <= pmc_pkg::DIV_RESET;
			pre_sel_r <= 1'b0;
			periph_gate_r <= pmc_pkg::PERIPH_GATE_RESET;
		end else if (CE && wr_en) begin
			unique case (PADDR)
				pmc_pkg::OFS_REGULATOR_CONTROL: begin
					stop_sel_r <= PWDATA[pmc_pkg::RC_STOP_SELECT];
				end
				pmc_pkg::OFS_CLOCK_SELECT: begin
					src_sel_r <= PWDATA[pmc_pkg::CS_SRC_LSB +: 2];
					div_sel_r <= PWDATA[pmc_pkg::CS_DIV_LSB +: 3];
					pre_sel_r <= PWDATA[pmc_pkg::CS_PRESCALE];
				end
				pmc_pkg::OFS_PERIPH_GATE: begin
					periph_gate_r <= PWDATA[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ============================================================
	// Mode sequencer
	// Suspend and snooze wait until the fast 24.5 MHz source is really active
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			pmc_pkg::ST_NORMAL: begin
				if (stop_req_r) begin
					state_nxt = stop_sel_r ? pmc_pkg::ST_SHUTDOWN : pmc_pkg::ST_STOP;
				end else if ((suspend_req_r || snooze_req_r)
					&& CLK_SRC_SEL == pmc_pkg::SRC_OSC_24M5 && !clk_busy) begin
					state_nxt = suspend_req_r ? pmc_pkg::ST_SUSPEND : pmc_pkg::ST_SNOOZE;
				end else if (idle_req_r) begin
					state_nxt = pmc_pkg::ST_IDLE;
				end
			end
			pmc_pkg::ST_IDLE, pmc_pkg::ST_SUSPEND, pmc_pkg::ST_SNOOZE: begin
				if (wake_return) begin
					state_nxt = pmc_pkg::ST_NORMAL;
				end
			end
			pmc_pkg::ST_STOP, pmc_pkg::ST_SHUTDOWN: begin
				state_nxt = state_r;
			end
			default: begin
				state_nxt = pmc_pkg::ST_NORMAL;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST || soft_rst) begin
			state_r <= pmc_pkg::ST_NORMAL;
		end else if (CE) begin
			state_r <= state_nxt;
		end
	end

	// ============================================================
	// Power and clock enables
	assign running = (state_r == pmc_pkg::ST_NORMAL) | (state_r == pmc_pkg::ST_IDLE);
	assign low_power = (state_r == pmc_pkg::ST_SUSPEND) | (state_r == pmc_pkg::ST_SNOOZE);

	always_ff @(posedge CLK) begin
		if (SRST) begin
			CORE_CLK_EN <= 1'b1;
			PERIPH_CLK_EN <= pmc_pkg::PERIPH_GATE_RESET;
			OSC_24M5_EN <= 1'b1;
			OSC_72M_EN <= 1'b0;
			TIMER34_LF_CLK_EN <= 1'b0;
			REG_LOW_BIAS <= 1'b0;
			POWER_NETS_OFF <= 1'b0;
			PIN_RETAIN <= 1'b0;
		end else if (CE) begin
			CORE_CLK_EN <= state_r == pmc_pkg::ST_NORMAL;
			PERIPH_CLK_EN <= running ? periph_gate_r : 8'h00;
			OSC_24M5_EN <= running;
			OSC_72M_EN <= running & ((src_sel_r == pmc_pkg::SRC_OSC_72M)
				| (CLK_SRC_SEL == pmc_pkg::SRC_OSC_72M));
			TIMER34_LF_CLK_EN <= low_power & lf_timer_en_r;
			REG_LOW_BIAS <= state_r == pmc_pkg::ST_SNOOZE;
			POWER_NETS_OFF <= (state_r == pmc_pkg::ST_STOP) | (state_r == pmc_pkg::ST_SHUTDOWN);
			PIN_RETAIN <= (state_r == pmc_pkg::ST_STOP) | (state_r == pmc_pkg::ST_SHUTDOWN);
		end
	end

	// ============================================================
	// Submodules
	wake_detect u_wake (
		.clk          (CLK),
		.srst         (SRST),
		.ce           (CE),
		.timer4_event (TIMER4_EVENT),
		.spi_activity (SPI_ACTIVITY),
		.i2c_activity (I2C_SLAVE_ACTIVITY),
		.port_match   (PORT_MATCH),
		.cmp0_out     (CMP0_OUT),
		.clu_event    (CLU_IRQ_EVENT),
		.wake         (wake)
	);

	// Divider keeps running in idle since peripherals still need the clock
	clk_div_switch u_clk (
		.clk     (CLK),
		.srst    (SRST | soft_rst),
		.ce      (CE),
		.run     (running),
		.req_src (src_sel_r),
		.req_div (div_sel_r),
		.req_pre (pre_sel_r),
		.act_src (CLK_SRC_SEL),
		.act_div (CLK_DIV_SEL),
		.act_pre (CLK_PRESCALE_ON),
		.tick    (SYS_CLK_TICK),
		.busy    (clk_busy)
	);

	// ============================================================
	// Checks
	normal_run_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && state_r == pmc_pkg::ST_NORMAL |=> CORE_CLK_EN && PERIPH_CLK_EN == $past(periph_gate_r))
		else $error("normal mode does not clock core and peripherals");

	idle_wake_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && state_r == pmc_pkg::ST_IDLE && IRQ_ANY && !wr_en
		|=> state_r == pmc_pkg::ST_NORMAL && !idle_req_r)
		else $error("interrupt did not end idle");

	suspend_clock_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && state_r == pmc_pkg::ST_SUSPEND
		|=> !CORE_CLK_EN && !OSC_24M5_EN && !OSC_72M_EN && !REG_LOW_BIAS && PERIPH_CLK_EN == 8'h00)
		else $error("suspend left clocks or low bias wrong");

	lf_timer_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && (state_r == pmc_pkg::ST_SUSPEND || state_r == pmc_pkg::ST_SNOOZE) && lf_timer_en_r
		|=> TIMER34_LF_CLK_EN)
		else $error("timers three and four lost the low clock");

	resume_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && (state_r == pmc_pkg::ST_SUSPEND || state_r == pmc_pkg::ST_SNOOZE) && wake
		|=> state_r == pmc_pkg::ST_NORMAL && !suspend_req_r && !snooze_req_r && !stop_req_r
			|| $past(wr_en))
		else $error("wake did not resume normal mode");

	snooze_bias_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && state_r == pmc_pkg::ST_SNOOZE |=> REG_LOW_BIAS && !OSC_24M5_EN && !CORE_CLK_EN)
		else $error("snooze regulator bias wrong");

	stop_exit_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && state_r == pmc_pkg::ST_STOP && OTHER_RESET_EVENT
		|=> state_r == pmc_pkg::ST_NORMAL && !stop_req_r)
		else $error("reset did not end stop");

	shutdown_hold_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && state_r == pmc_pkg::ST_SHUTDOWN && EXTERNAL_RESET_PIN_N && !POR_EVENT
		|=> state_r == pmc_pkg::ST_SHUTDOWN ##1 POWER_NETS_OFF && PIN_RETAIN)
		else $error("shutdown left without pin or power-on reset");

endmodule : power_mode_ctrl
`default_nettype wire

// File: wake_detect.sv
`timescale 1ns/1ns
`default_nettype none
module wake_detect (
	// Clock and control
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic ce,
	// Wake sources
	input  wire logic timer4_event,
	input  wire logic spi_activity,
	input  wire logic i2c_activity,
	input  wire logic port_match,
	input  wire logic cmp0_out,
	input  wire logic clu_event,
	// Result
	output logic      wake
);

	logic cmp0_d_r;
	logic cmp0_fall;

	assign cmp0_fall = cmp0_d_r & ~cmp0_out;

	always_ff @(posedge clk) begin
		if (srst) begin
			cmp0_d_r <= 1'b0;
		end else if (ce) begin
			cmp0_d_r <= cmp0_out;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wake <= 1'b0;
		end else if (ce) begin
			wake <= timer4_event | spi_activity | i2c_activity | port_match | cmp0_fall | clu_event;
		end
	end

	wake_any_a: assert property (@(posedge clk) disable iff (srst)
		ce && (timer4_event || spi_activity || i2c_activity || port_match || clu_event
		|| ($past(cmp0_out) && !cmp0_out && $past(ce) && !$past(srst))) |=> wake)
		else $error("wake source not reported");

endmodule : wake_detect
`default_nettype wire
